// [ahc_pkg.sv]
// Shared constants for the auxiliary supply and high-side mode control.
// Assumes a single core clock; mode codes come from the device state machine.
package ahc_pkg;

  // ==========================================================
  // Operating modes (Gray along normal-stop-sleep-restart-failsafe)
  typedef enum logic [2:0] {
    AHC_MODE_NORMAL   = 3'h0,
    AHC_MODE_STOP     = 3'h1,
    AHC_MODE_SLEEP    = 3'h3,
    AHC_MODE_RESTART  = 3'h2,
    AHC_MODE_FAILSAFE = 3'h6
  } ahc_mode_t;

  // ==========================================================
  // Regulator stage control states
  typedef enum logic [1:0] {
    AHC_STG_OFF  = 2'h0,
    AHC_STG_LOW  = 2'h1,
    AHC_STG_BOTH = 2'h3
  } ahc_stage_t;

  // ==========================================================
  // High-side configuration field
  localparam int AHC_NUM_HS = 4;
  localparam int AHC_CODE_W = 3;
  localparam logic [2:0] AHC_HS_OFF = 3'h0;
  localparam logic [2:0] AHC_HS_ON = 3'h1;
  localparam logic [2:0] AHC_HS_TIMER1 = 3'h2;
  localparam logic [2:0] AHC_HS_TIMER2 = 3'h3;
  localparam logic [2:0] AHC_HS_PWM1 = 3'h4;
  localparam logic [2:0] AHC_HS_PWM2 = 3'h5;

  // ==========================================================
  // Reset values
  localparam logic AHC_AUX_EN_RST = 1'h0;
  localparam logic [2:0] AHC_HS_CODE_RST = AHC_HS_OFF;

endpackage

// [ahc_sync.sv]
// Two-flop synchroniser for a group of asynchronous level inputs.
// Assumes the inputs are quasi-static levels from analog comparators.
`timescale 1ns/1ns
module ahc_sync
  import ahc_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Levels
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1;

  // ==========================================================
  // Synchroniser; first stage feeds only the second
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      stage1 <= '0;
      syncOut <= '0;
    end
    else
    begin
      stage1 <= asyncIn;
      syncOut <= stage1;
    end
  end

endmodule

// [ahc_hs_channel.sv]
// One high-side output channel: configuration field, source mux, protection.
// Assumes write strobes are already qualified by the operating mode.
`timescale 1ns/1ns
module ahc_hs_channel
  import ahc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Host configuration
  input wire logic cfgWrite,
  input wire logic [2:0] cfgCode,
  input wire logic ocFlagClear,
  input wire logic olFlagClear,
  // Control from the top
  input wire logic forceOff,
  input wire logic supplyFaultOff,
  input wire logic clearOnSupplyFault,
  // Sources
  input wire logic timer1,
  input wire logic timer2,
  input wire logic pwm1,
  input wire logic pwm2,
  // Synchronised sense inputs
  input wire logic overCurrent,
  input wire logic underCurrent,
  // Results
  output logic [2:0] code,
  output logic hsOut,
  output logic ocFlag,
  output logic olFlag
);

  logic [2:0] next_code;
  logic next_hsOut;
  logic next_ocFlag;
  logic next_olFlag;
  logic srcLevel;

  // ==========================================================
  // Next-state logic
  always_comb
  begin
    next_code = code;
    next_ocFlag = ocFlag;
    next_olFlag = olFlag;
    case (code)
      AHC_HS_ON: srcLevel = 1'b1;
      AHC_HS_TIMER1: srcLevel = timer1;
      AHC_HS_TIMER2: srcLevel = timer2;
      AHC_HS_PWM1: srcLevel = pwm1;
      AHC_HS_PWM2: srcLevel = pwm2;
      default: srcLevel = 1'b0;
    endcase
    if (cfgWrite)
      next_code = cfgCode;
    // Protection beats a same-cycle write
    if (supplyFaultOff && clearOnSupplyFault)
      next_code = AHC_HS_OFF;
    if (hsOut && overCurrent)
    begin
      next_code = AHC_HS_OFF;
    end
    if (forceOff)
      next_code = AHC_HS_OFF;
    // Sticky flags: a new event wins over the clear
    if (ocFlagClear)
      next_ocFlag = 1'b0;
    if (hsOut && overCurrent)
      next_ocFlag = 1'b1;
    if (olFlagClear)
      next_olFlag = 1'b0;
    if (hsOut && underCurrent)
      next_olFlag = 1'b1;
    next_hsOut = srcLevel && !supplyFaultOff && !forceOff
      && !(hsOut && overCurrent);
  end

  // ==========================================================
  // Registers
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      code <= AHC_HS_CODE_RST;
      hsOut <= 1'b0;
      ocFlag <= 1'b0;
      olFlag <= 1'b0;
    end
    else
    begin
      code <= next_code;
      hsOut <= next_hsOut;
      ocFlag <= next_ocFlag;
      olFlag <= next_olFlag;
    end
  end

endmodule

// [ahc_top.sv]
// Auxiliary 5 V regulator and four high-side switch mode control.
// Assumes mode, host writes and timer/PWM sources are on core_clk;
// comparator and sense inputs are asynchronous and get synchronised.
//
// Contract
// - Aux regulator allowed normal/stop/sleep, off fail-safe
// - Restart entry switches aux regulator off
// - Restart shutdown latched until host writes the enable
// - Normal mode: host turns aux regulator on/off
// - Stop: low stage, high stage above rise
// - Below fall threshold, high stage disabled
// - Normal mode: both regulator stages enabled
// - Output source: direct, timer, or PWM
// - Stop/sleep keep high-side configuration, ignore writes
// - Restart/fail-safe entry forces high-side outputs off
// - Supply OV/UV turn outputs off, each disableable
// - Recovery after OV/UV selectable by bit
// - Over-current switches that output off
// - Open load evaluated only while output on
// - No recovery: outputs stay off, fields cleared
// - Over-current resets field to off code
`timescale 1ns/1ns
module ahc_top
  import ahc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Operating mode from the device state machine
  input wire ahc_mode_t opMode,
  // Host writes for the auxiliary regulator
  input wire logic auxEnableWrite,
  input wire logic auxEnableData,
  // Host writes for high-side control fields
  input wire logic hsCfgWrite,
  input wire logic [1:0] hsCfgIndex,
  input wire logic [2:0] hsCfgCode,
  input wire logic [3:0] hsOcFlagClear,
  input wire logic [3:0] hsOlFlagClear,
  // Host configuration levels
  input wire logic supplyFaultRecoveryEnable,
  input wire logic overvoltageShutdownDisable,
  input wire logic undervoltageShutdownDisable,
  // Internal timer and PWM sources
  input wire logic timer1,
  input wire logic timer2,
  input wire logic pwm1,
  input wire logic pwm2,
  // Asynchronous analog comparators
  input wire logic auxLoadAboveRise,
  input wire logic auxLoadBelowFall,
  input wire logic highsideSupplyOv,
  input wire logic highsideSupplyUv,
  input wire logic [3:0] hsOverCurrent,
  input wire logic [3:0] hsUnderCurrent,
  // Regulator controls
  output logic auxRegulatorEnable,
  output logic auxLowPowerStage,
  output logic auxHighPowerStage,
  output logic auxShutdownLatched,
  // High-side outputs and status
  output logic [3:0] highsideOutputN,
  output logic [11:0] highsideControlReadback,
  output logic [3:0] hsOcFlag,
  output logic [3:0] hsOlFlag,
  output logic supplyOvActive,
  output logic supplyUvActive
);

  // ==========================================================
  // Synchronisers
  // One shared chain; packing order must match the unpacking below
  logic [11:0] levelsIn;
  logic [11:0] levelsSync;
  logic [1:0] loadSync;
  logic [1:0] supplySync;
  logic [3:0] ocSync;
  logic [3:0] ulSync;

  always_comb
  begin
    levelsIn = {hsUnderCurrent, hsOverCurrent, highsideSupplyUv,
      highsideSupplyOv, auxLoadBelowFall, auxLoadAboveRise};
    loadSync = levelsSync[1:0];
    supplySync = levelsSync[3:2];
    ocSync = levelsSync[7:4];
    ulSync = levelsSync[11:8];
  end

  ahc_sync #(.WIDTH(12)) u_sync (
    .core_clk(core_clk),
    .srst(srst),
    .asyncIn(levelsIn),
    .syncOut(levelsSync)
  );

  // ==========================================================
  // Mode entry decode
  ahc_mode_t prevMode;
  ahc_mode_t next_prevMode;
  logic modeChanged;
  logic enterRestart;
  logic enterFailsafe;
  logic inNormal;
  logic inLowPower;

  always_comb
  begin
    next_prevMode = opMode;
    modeChanged = (opMode != prevMode);
    enterRestart = modeChanged && (opMode == AHC_MODE_RESTART);
    enterFailsafe = modeChanged && (opMode == AHC_MODE_FAILSAFE);
    inNormal = (opMode == AHC_MODE_NORMAL);
    inLowPower = (opMode == AHC_MODE_STOP) || (opMode == AHC_MODE_SLEEP);
  end

  // Reset to normal: a restart or fail-safe level at release
  // counts as an entry, the safe reading
  always_ff @(posedge core_clk)
  begin
    if (srst)
      prevMode <= AHC_MODE_NORMAL;
    else
      prevMode <= next_prevMode;
  end

  // ==========================================================
  // Auxiliary regulator enable
  logic auxEnable;
  logic next_auxEnable;
  logic next_auxShutdownLatched;
  logic next_auxRegulatorEnable;

  always_comb
  begin
    next_auxEnable = auxEnable;
    next_auxShutdownLatched = auxShutdownLatched;
    // Writes outside normal mode are dropped; host sets state beforehand
    // Either value releases the latch; the host owns the state again
    if (auxEnableWrite && inNormal)
    begin
      next_auxEnable = auxEnableData;
      next_auxShutdownLatched = 1'b0;
    end
    // Restart entry wins over a same-cycle write
    if (enterRestart)
    begin
      next_auxEnable = 1'b0;
      next_auxShutdownLatched = 1'b1;
    end
    // Fail-safe gates the pin only; the stored enable survives
    next_auxRegulatorEnable = next_auxEnable
      && (opMode != AHC_MODE_FAILSAFE)
      && (opMode != AHC_MODE_RESTART);
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      auxEnable <= AHC_AUX_EN_RST;
      auxShutdownLatched <= 1'b0;
      auxRegulatorEnable <= 1'b0;
    end
    else
    begin
      auxEnable <= next_auxEnable;
      auxShutdownLatched <= next_auxShutdownLatched;
      auxRegulatorEnable <= next_auxRegulatorEnable;
    end
  end

  // ==========================================================
  // Regulator stage control
  ahc_stage_t stage;
  ahc_stage_t next_stage;
  logic next_auxLowPowerStage;
  logic next_auxHighPowerStage;

  always_comb
  begin
    next_stage = stage;
    if (!next_auxRegulatorEnable)
      next_stage = AHC_STG_OFF;
    else if (inNormal)
      next_stage = AHC_STG_BOTH;
    else
    begin
      // Low-power modes: hysteresis between the two comparators
      // Both stages held from normal until light load is reported
      case (stage)
        AHC_STG_OFF: next_stage = AHC_STG_LOW;
        AHC_STG_LOW:
          if (loadSync[0])
            next_stage = AHC_STG_BOTH;
        AHC_STG_BOTH:
          if (inLowPower && loadSync[1])
            next_stage = AHC_STG_LOW;
        default: next_stage = AHC_STG_OFF;
      endcase
    end
    next_auxLowPowerStage = (next_stage != AHC_STG_OFF);
    next_auxHighPowerStage = (next_stage == AHC_STG_BOTH);
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      stage <= AHC_STG_OFF;
      auxLowPowerStage <= 1'b0;
      auxHighPowerStage <= 1'b0;
    end
    else
    begin
      stage <= next_stage;
      auxLowPowerStage <= next_auxLowPowerStage;
      auxHighPowerStage <= next_auxHighPowerStage;
    end
  end

  // ==========================================================
  // High-side supply fault gating
  logic next_supplyOvActive;
  logic next_supplyUvActive;
  logic supplyFaultOff;
  logic forceOff;
  logic cfgAccepted;
  logic clearOnFault;

  always_comb
  begin
    // Status follows the synced level even with the shutdown disabled
    next_supplyOvActive = supplySync[0];
    next_supplyUvActive = supplySync[1];
    // Each shutdown path can be disabled on its own
    supplyFaultOff = (supplySync[0] && !overvoltageShutdownDisable)
      || (supplySync[1] && !undervoltageShutdownDisable);
    forceOff = enterRestart || enterFailsafe
      || (opMode == AHC_MODE_RESTART)
      || (opMode == AHC_MODE_FAILSAFE);
    // Config is frozen outside normal mode
    cfgAccepted = hsCfgWrite && inNormal;
    clearOnFault = !supplyFaultRecoveryEnable;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      supplyOvActive <= 1'b0;
      supplyUvActive <= 1'b0;
    end
    else
    begin
      supplyOvActive <= next_supplyOvActive;
      supplyUvActive <= next_supplyUvActive;
    end
  end

  // ==========================================================
  // High-side channels
  // Index decoded once instead of in every instance
  logic [3:0] chanWrite;

  always_comb
  begin
    chanWrite = 4'h0;
    if (cfgAccepted)
      chanWrite[hsCfgIndex] = 1'b1;
  end

  genvar ch;
  generate
    for (ch = 0; ch < AHC_NUM_HS; ch++)
    begin : g_hs
      ahc_hs_channel u_chan (
        .core_clk(core_clk),
        .srst(srst),
        .cfgWrite(chanWrite[ch]),
        .cfgCode(hsCfgCode),
        .ocFlagClear(hsOcFlagClear[ch]),
        .olFlagClear(hsOlFlagClear[ch]),
        .forceOff(forceOff),
        .supplyFaultOff(supplyFaultOff),
        .clearOnSupplyFault(clearOnFault),
        .timer1(timer1),
        .timer2(timer2),
        .pwm1(pwm1),
        .pwm2(pwm2),
        .overCurrent(ocSync[ch]),
        .underCurrent(ulSync[ch]),
        .code(highsideControlReadback[ch*3 +: 3]),
        .hsOut(highsideOutputN[ch]),
        .ocFlag(hsOcFlag[ch]),
        .olFlag(hsOlFlag[ch])
      );
    end
  endgenerate

endmodule

// [ahc_top_chk.sv]
// Port assertions for the aux supply and high-side mode control.
// Assumes binding into ahc_top on one clock with synchronous reset.
`timescale 1ns/1ns
module ahc_top_chk
  import ahc_pkg::*;
(
  // Clock, reset and inputs
  input wire logic core_clk,
  input wire logic srst,
  input wire ahc_mode_t opMode,
  input wire logic auxEnableWrite,
  input wire logic auxEnableData,
  input wire logic hsCfgWrite,
  input wire logic [1:0] hsCfgIndex,
  input wire logic [2:0] hsCfgCode,
  input wire logic overvoltageShutdownDisable,
  input wire logic auxLoadAboveRise,
  input wire logic auxLoadBelowFall,
  input wire logic highsideSupplyOv,
  input wire logic [3:0] hsOverCurrent,
  // Outputs
  input wire logic auxRegulatorEnable,
  input wire logic auxLowPowerStage,
  input wire logic auxHighPowerStage,
  input wire logic auxShutdownLatched,
  input wire logic [3:0] highsideOutputN,
  input wire logic [11:0] highsideControlReadback,
  input wire logic [3:0] hsOlFlag
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);
  // ==========================================
  // Sequences
  // Four cycles cover the two-flop sync plus the stage register
  sequence s_stop_rise;
    (opMode == AHC_MODE_STOP && auxLoadAboveRise && !auxLoadBelowFall)[*4];
  endsequence
  sequence s_stop_fall;
    (opMode == AHC_MODE_STOP && auxLoadBelowFall && !auxLoadAboveRise)[*4];
  endsequence
  sequence s_restart_entry;
    opMode == AHC_MODE_RESTART && $past(opMode) != AHC_MODE_RESTART;
  endsequence
  // ==========================================
  // Assertions
  chk_failsafe_aux_off: assert property (
    opMode == AHC_MODE_FAILSAFE |=> !auxRegulatorEnable)
    else $error("aux enabled in fail-safe");
  chk_restart_aux_off: assert property (
    s_restart_entry |=> !auxRegulatorEnable && auxShutdownLatched)
    else $error("aux not shut down on restart");
  chk_latch_holds: assert property (
    auxShutdownLatched && !(auxEnableWrite && opMode == AHC_MODE_NORMAL)
    |=> auxShutdownLatched && !auxRegulatorEnable)
    else $error("restart latch released without write");
  chk_aux_write: assert property (
    auxEnableWrite && opMode == AHC_MODE_NORMAL
    |=> auxRegulatorEnable == $past(auxEnableData))
    else $error("aux write not applied");
  chk_normal_stages: assert property (
    auxRegulatorEnable && $past(opMode) == AHC_MODE_NORMAL
    |-> auxLowPowerStage && auxHighPowerStage)
    else $error("normal mode stages not both on");
  chk_stop_rise: assert property (
    s_stop_rise ##0 auxRegulatorEnable |-> auxHighPowerStage)
    else $error("high stage not added on rise");
  chk_stop_fall: assert property (
    s_stop_fall |-> !auxHighPowerStage)
    else $error("high stage kept after fall");
  chk_hs_forced_off: assert property (
    opMode == AHC_MODE_RESTART || opMode == AHC_MODE_FAILSAFE
    |=> highsideOutputN == 4'h0 && highsideControlReadback == 12'h000)
    else $error("high-side not forced off");
  chk_hs_write: assert property (
    hsCfgWrite && hsCfgIndex == 2'h1 && opMode == AHC_MODE_NORMAL
    |=> highsideControlReadback[5:3] == $past(hsCfgCode))
    else $error("high-side write not stored");
  chk_ov_off: assert property (
    (highsideSupplyOv && !overvoltageShutdownDisable)[*3]
    |=> highsideOutputN == 4'h0)
    else $error("outputs on during over-voltage");
  chk_oc_off: assert property (
    (hsOverCurrent[0] && highsideOutputN[0])[*3]
    |=> !highsideOutputN[0] && highsideControlReadback[2:0] == AHC_HS_OFF)
    else $error("over-current did not switch off");
  chk_ol_when_on: assert property (
    $rose(hsOlFlag[0]) |-> $past(highsideOutputN[0]))
    else $error("open load flagged while off");
endmodule

bind ahc_top ahc_top_chk u_chk (.core_clk, .srst, .opMode, .auxEnableWrite,
  .auxEnableData, .hsCfgWrite, .hsCfgIndex, .hsCfgCode,
  .overvoltageShutdownDisable, .auxLoadAboveRise, .auxLoadBelowFall,
  .highsideSupplyOv, .hsOverCurrent, .auxRegulatorEnable, .auxLowPowerStage,
  .auxHighPowerStage, .auxShutdownLatched, .highsideOutputN,
  .highsideControlReadback, .hsOlFlag);

// [ahc_host_model.sv]
// Host model: turns bench requests into write strobes for the block.
// Assumes requests are driven on the rising edge of the core clock.
`timescale 1ns/1ns
module ahc_host_model
  import ahc_pkg::*;
(
  // Mode and misbehaviour control
  input wire ahc_mode_t opMode,
  input wire logic rogue,
  // Requests
  input wire logic reqAux,
  input wire logic reqAuxData,
  input wire logic reqHs,
  input wire logic [1:0] reqIdx,
  input wire logic [2:0] reqCode,
  // Write strobes
  output logic auxEnableWrite,
  output logic auxEnableData,
  output logic hsCfgWrite,
  output logic [1:0] hsCfgIndex,
  output logic [2:0] hsCfgCode
);
  logic allowed;
  // Rogue lets a scenario write outside normal mode on purpose
  assign allowed = opMode == AHC_MODE_NORMAL || rogue;
  assign auxEnableWrite = reqAux && allowed;
  assign hsCfgWrite = reqHs && allowed;
  // Idle data is inverted so nothing leans on a stale value
  assign auxEnableData = reqAux ? reqAuxData : ~reqAuxData;
  assign hsCfgIndex = reqHs ? reqIdx : ~reqIdx;
  assign hsCfgCode = reqHs ? reqCode : ~reqCode;
endmodule

// [tb_ahc_top.sv]
// Self-checking bench for the aux supply and high-side control.
// Assumes the host model and checker compile alongside the design.
`timescale 1ns/1ns
module tb_ahc_top;
  import ahc_pkg::*;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  ahc_mode_t opMode = AHC_MODE_NORMAL;
  logic rogue = 1'b0, reqAux = 1'b0, reqAuxData = 1'b0, reqHs = 1'b0;
  logic [1:0] reqIdx = 2'h0;
  logic [2:0] reqCode = 3'h0;
  logic [3:0] ocClr = 4'h0, olClr = 4'h0;
  logic auxEnableWrite, auxEnableData, hsCfgWrite;
  logic [1:0] hsCfgIndex;
  logic [2:0] hsCfgCode;
  logic supplyFaultRecoveryEnable = 1'b0, overvoltageShutdownDisable = 1'b0;
  logic undervoltageShutdownDisable = 1'b0, auxLoadAboveRise = 1'b0;
  logic auxLoadBelowFall = 1'b0, highsideSupplyOv = 1'b0;
  logic highsideSupplyUv = 1'b0;
  logic [3:0] src = 4'h0, hsOverCurrent = 4'h0, hsUnderCurrent = 4'h0;
  logic [3:0] p, highsideOutputN, hsOcFlag, hsOlFlag;
  logic auxRegulatorEnable, auxLowPowerStage, auxHighPowerStage;
  logic auxShutdownLatched, supplyOvActive, supplyUvActive;
  logic [11:0] highsideControlReadback;
  int err_count = 0, checks_done = 0, cycles = 0;

  ahc_host_model host (.opMode, .rogue, .reqAux, .reqAuxData, .reqHs, .reqIdx,
    .reqCode, .auxEnableWrite, .auxEnableData, .hsCfgWrite, .hsCfgIndex,
    .hsCfgCode);
  ahc_top uut (.core_clk, .srst, .opMode, .auxEnableWrite, .auxEnableData,
    .hsCfgWrite, .hsCfgIndex, .hsCfgCode, .hsOcFlagClear(ocClr),
    .hsOlFlagClear(olClr), .supplyFaultRecoveryEnable,
    .overvoltageShutdownDisable, .undervoltageShutdownDisable,
    .timer1(src[0]), .timer2(src[1]), .pwm1(src[2]), .pwm2(src[3]),
    .auxLoadAboveRise, .auxLoadBelowFall, .highsideSupplyOv, .highsideSupplyUv,
    .hsOverCurrent, .hsUnderCurrent, .auxRegulatorEnable, .auxLowPowerStage,
    .auxHighPowerStage, .auxShutdownLatched, .highsideOutputN,
    .highsideControlReadback, .hsOcFlag, .hsOlFlag, .supplyOvActive,
    .supplyUvActive);

  // ==========================================
  // Clock, sources and timeout
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    src <= src + 4'h1;
    cycles++;
    if (cycles == 3000)
    begin
      err_count++;
      test_done();
    end
  end

  // ==========================================
  // Helpers
  task automatic check(input string what, input logic [15:0] seen,
    input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic waitc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic setMode(input ahc_mode_t m);
    @(posedge core_clk);
    opMode <= m;
  endtask
  task automatic auxWr(input logic d);
    @(posedge core_clk);
    reqAux <= 1'b1;
    reqAuxData <= d;
    @(posedge core_clk);
    reqAux <= 1'b0;
    #1;
  endtask
  task automatic hsWr(input logic [1:0] i, input logic [2:0] c);
    @(posedge core_clk);
    reqHs <= 1'b1;
    reqIdx <= i;
    reqCode <= c;
    @(posedge core_clk);
    reqHs <= 1'b0;
    #1;
  endtask

  // ==========================================
  // Scenarios
  task automatic t_aux();
    check("rst aux", auxRegulatorEnable, 1'b0);
    check("rst hs", highsideControlReadback, 12'h000);
    auxWr(1'b1);
    check("aux on", auxRegulatorEnable, 1'b1);
    check("stages", {auxLowPowerStage, auxHighPowerStage}, 2'h3);
    setMode(AHC_MODE_RESTART);
    waitc(1);
    check("restart", {auxRegulatorEnable, auxShutdownLatched},
      2'h1);
    setMode(AHC_MODE_NORMAL);
    waitc(3);
    check("latched", auxRegulatorEnable, 1'b0);
    auxWr(1'b1);
    check("reenable", {auxRegulatorEnable, auxShutdownLatched},
      2'h2);
    setMode(AHC_MODE_FAILSAFE);
    waitc(2);
    check("failsafe", auxRegulatorEnable, 1'b0);
    setMode(AHC_MODE_NORMAL);
    waitc(2);
    check("kept", auxRegulatorEnable, 1'b1);
    $display("test aux done");
  endtask
  task automatic t_stop();
    // Light load, so stop mode drops to the low stage
    @(posedge core_clk);
    auxLoadBelowFall <= 1'b1;
    setMode(AHC_MODE_STOP);
    @(posedge core_clk);
    rogue <= 1'b1;
    waitc(1);
    check("low only", {auxLowPowerStage, auxHighPowerStage}, 2'h2);
    auxWr(1'b0);
    waitc(1);
    check("stop lock", auxRegulatorEnable, 1'b1);
    @(posedge core_clk);
    rogue <= 1'b0;
    auxLoadAboveRise <= 1'b1;
    auxLoadBelowFall <= 1'b0;
    waitc(5);
    check("rise", auxHighPowerStage, 1'b1);
    @(posedge core_clk);
    auxLoadAboveRise <= 1'b0;
    auxLoadBelowFall <= 1'b1;
    waitc(5);
    check("fall", {auxLowPowerStage, auxHighPowerStage}, 2'h2);
    setMode(AHC_MODE_NORMAL);
    auxLoadBelowFall <= 1'b0;
    $display("test stop done");
  endtask
  task automatic t_hs();
    hsWr(2'h1, AHC_HS_ON);
    check("code", highsideControlReadback[5:3], AHC_HS_ON);
    waitc(1);
    check("on", highsideOutputN[1], 1'b1);
    for (int c = 2; c < 6; c++)
    begin
      hsWr(2'h2, 3'(c));
      repeat (4)
      begin
        waitc(1);
        p = src - 4'h1;
        check("source", highsideOutputN[2], p[c-2]);
      end
    end
    setMode(AHC_MODE_SLEEP);
    @(posedge core_clk);
    rogue <= 1'b1;
    hsWr(2'h1, AHC_HS_OFF);
    waitc(2);
    check("lock", {highsideOutputN[1], highsideControlReadback[5:3]},
      4'h9);
    setMode(AHC_MODE_RESTART);
    rogue <= 1'b0;
    waitc(2);
    check("forced", {highsideOutputN, highsideControlReadback},
      16'h0);
    setMode(AHC_MODE_NORMAL);
    $display("test highside done");
  endtask
  task automatic t_prot();
    hsWr(2'h0, AHC_HS_ON);
    hsWr(2'h1, AHC_HS_ON);
    @(posedge core_clk);
    overvoltageShutdownDisable <= 1'b1;
    undervoltageShutdownDisable <= 1'b1;
    highsideSupplyOv <= 1'b1;
    highsideSupplyUv <= 1'b1;
    waitc(5);
    check("disabled", highsideOutputN[1:0], 2'h3);
    @(posedge core_clk);
    overvoltageShutdownDisable <= 1'b0;
    undervoltageShutdownDisable <= 1'b0;
    highsideSupplyUv <= 1'b0;
    supplyFaultRecoveryEnable <= 1'b1;
    waitc(5);
    check("ov off", {supplyOvActive, highsideOutputN}, 5'h10);
    @(posedge core_clk);
    highsideSupplyOv <= 1'b0;
    waitc(5);
    check("resume", highsideOutputN[1:0], 2'h3);
    @(posedge core_clk);
    supplyFaultRecoveryEnable <= 1'b0;
    highsideSupplyUv <= 1'b1;
    waitc(5);
    check("uv off", {supplyUvActive, highsideOutputN}, 5'h10);
    @(posedge core_clk);
    highsideSupplyUv <= 1'b0;
    waitc(5);
    check("no resume", {highsideOutputN, highsideControlReadback},
      16'h0);
    hsWr(2'h0, AHC_HS_ON);
    @(posedge core_clk);
    hsUnderCurrent <= 4'h3;
    waitc(5);
    check("open load", {hsOlFlag, highsideOutputN[0]}, 5'h3);
    @(posedge core_clk);
    hsOverCurrent <= 4'h1;
    waitc(5);
    check("oc", {hsOcFlag[0], highsideOutputN[0]}, 2'h2);
    check("oc code", highsideControlReadback[2:0], AHC_HS_OFF);
    // Sense still active, output off: cleared flags must stay clear
    @(posedge core_clk);
    ocClr <= 4'h1;
    olClr <= 4'h1;
    @(posedge core_clk);
    ocClr <= 4'h0;
    olClr <= 4'h0;
    waitc(2);
    check("flag clr", {hsOcFlag[0], hsOlFlag[0]}, 2'h0);
    $display("test protection done");
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    waitc(1);
    t_aux();
    t_stop();
    t_hs();
    t_prot();
    test_done();
  end
endmodule
